// >>> ccad_regs.vh
// constants, field layout and timing of the cpu core alu datapath
// What this block does
// - separate program and data memories; each instruction is one 14-bit word
// - fetch overlaps execute; one cycle per instruction except branches
// - at 20 MHz oscillator one instruction cycle lasts 200 ns
// - program memory is 4K x 14 words, all on chip, only source
// - data reached by direct address or indirectly through the pointer
// - special registers, program counter too, live in data space
// - 8-bit alu: add, subtract, shift and bitwise logic
// - arithmetic operands and results are two's complement
// - two-operand ops use accumulator and a file register or literal
// - single-operand ops use accumulator or a file register
// - 8-bit working accumulator has no data space address
// - alu updates carry, digit carry and zero in status per instruction
// - on subtraction carry and digit carry mean no borrow
// - in rc mode clock output runs at a quarter of oscillator
// - master clear low resets the device; high lets it run
// - four phases per cycle; operand read in second, write in fourth
// - execution starts at 0000h; interrupts vector to 0004h with pcHi_ff[4:3] as upper pc bits
// - program addresses beyond 4K wrap into the first 4K words
`ifndef CCAD_REGS_VH
`define CCAD_REGS_VH
`define CCAD_INSTR_W      14
`define CCAD_PROG_AW      12
`define CCAD_PC_W         13
`define CCAD_PCHI_W       5
`define CCAD_OSC_MAX_MHZ  20
`define CCAD_INSTR_NS     200
`define CCAD_QPHASES      ((`CCAD_INSTR_NS * `CCAD_OSC_MAX_MHZ) / 1000)
`define CCAD_STACK_DEPTH  8
`define CCAD_RESET_VEC    13'h0000
`define CCAD_NOP          14'h0000
`define CCAD_IRQ_CALL     14'h2004
`define CCAD_STATUS_RST   8'h18
`define CCAD_ST_C         0
`define CCAD_ST_DCY       1
`define CCAD_ST_Z         2
`define CCAD_ST_RP0       5
`define CCAD_A_INDIRECT   7'h00
`define CCAD_A_PCLO       7'h02
`define CCAD_A_STAT       7'h03
`define CCAD_A_PTR        7'h04
`define CCAD_A_PCHI       7'h0A
`define CCAD_F_RET        7'h08
`define CCAD_F_RETIE      7'h09
`define CCAD_CLS_BYTE     2'b00
`define CCAD_CLS_BIT      2'b01
`define CCAD_CLS_JUMP     2'b10
`define CCAD_CLS_LIT      2'b11
`define CCAD_OP_MOVW      4'h0
`define CCAD_OP_CLR       4'h1
`define CCAD_OP_SUB       4'h2
`define CCAD_OP_DEC       4'h3
`define CCAD_OP_IOR       4'h4
`define CCAD_OP_AND       4'h5
`define CCAD_OP_XOR       4'h6
`define CCAD_OP_ADD       4'h7
`define CCAD_OP_MOV       4'h8
`define CCAD_OP_COM       4'h9
`define CCAD_OP_INC       4'hA
`define CCAD_OP_DECSZ     4'hB
`define CCAD_OP_RRF       4'hC
`define CCAD_OP_RLF       4'hD
`define CCAD_OP_SWAP      4'hE
`define CCAD_OP_INCSZ     4'hF
`define CCAD_LOP_MOVE     4'b00??
`define CCAD_LOP_RET      4'b01??
`define CCAD_LOP_IOR      4'b1000
`define CCAD_LOP_AND      4'b1001
`define CCAD_LOP_XOR      4'b1010
`define CCAD_LOP_SUB      4'b110?
`define CCAD_LOP_ADD      4'b111?
`endif

// >>> ccad_core.v
// cpu core: phase sequencer, two-stage pipeline, alu and core registers
`timescale 1ns/100ps
`include "ccad_regs.vh"
module ccad_core #(
   parameter STACK_DEPTH = `CCAD_STACK_DEPTH, // return stack levels
   parameter SP_W        = 3                  // stack pointer width
) (
   input  wire                      clk,                // oscillator clock
   input  wire                      rst,                // async reset
   input  wire                      ce,                 // clock enable
   input  wire                      masterClearInN,     // master clear pin
   input  wire                      rcModeSel,          // rc osc fuse
   output wire [`CCAD_PROG_AW-1:0]  progAddr,           // program address
   input  wire [`CCAD_INSTR_W-1:0]  progData,           // program word
   output wire [7:0]                dataAddr,           // data address
   output wire                      dataRdEn,           // data read strobe
   input  wire [7:0]                dataRdData,         // data read value
   output wire                      dataWrEn,           // data write strobe
   output wire [7:0]                dataWrData,         // data write value
   input  wire                      intReq,             // interrupt request
   output wire                      intAck,             // interrupt taken
   output wire                      instrRateClockOut   // quarter-rate clock
);
   localparam PHW = `CCAD_QPHASES;
   localparam [PHW-1:0] PH_Q1 = 4'b0001;
   localparam [PHW-1:0] PH_Q2 = 4'b0010;
   localparam [PHW-1:0] PH_Q3 = 4'b0100;
   localparam [PHW-1:0] PH_Q4 = 4'b1000;

   reg  [PHW-1:0]              phase_ff;
   reg                         mclrMeta_ff;
   reg                         mclrSync_ff;
   reg  [`CCAD_PC_W-1:0]       programCounter_ff;
   reg  [`CCAD_INSTR_W-1:0]    instr_ff;
   reg  [7:0]                  wReg_ff;
   reg  [7:0]                  status_ff;
   reg  [7:0]                  ptrReg_ff;
   reg  [`CCAD_PCHI_W-1:0]     pcHi_ff;
   reg  [7:0]                  operand_ff;
   reg  [`CCAD_PC_W-1:0]       stack_ff [0:STACK_DEPTH-1];
   reg  [SP_W-1:0]             sp_ff;
   reg  [7:0]                  dataAddr_ff;
   reg  [7:0]                  dataWrData_ff;
   reg                         dataRdEn_ff;
   reg                         dataWrEn_ff;
   reg                         intAck_ff;
   reg                         irqEnable_ff;
   reg                         instr_rate_clock_out_ff;

   // returns {carry, digit carry, sum}
   function [9:0] addc;
      input [7:0] a;
      input [7:0] b;
      input       cin;
      reg   [4:0] lo;
      reg   [4:0] hi;
      begin
         lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
         hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
         addc = {hi[4], lo[4], hi[3:0], lo[3:0]};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // decode and operand addressing
   wire                coreRst  = ~mclrSync_ff;
   wire [1:0]          opClass  = instr_ff[13:12];
   wire [3:0]          opCode   = instr_ff[11:8];
   wire                destFile = instr_ff[7];
   wire [6:0]          fileSel  = instr_ff[6:0];
   wire [7:0]          literal  = instr_ff[7:0];
   wire [7:0]          bitMask  = 8'h01 << instr_ff[9:7];
   wire                isLit    = (opClass == `CCAD_CLS_LIT);
   wire                indirect = (fileSel == `CCAD_A_INDIRECT);
   // pointer replaces the address field when the indirect slot is named
   wire [7:0]          effAddr  = indirect ? ptrReg_ff :
                                  {status_ff[`CCAD_ST_RP0], fileSel};
   wire [6:0]          regSel   = effAddr[6:0];

   reg                 coreHit;
   reg  [7:0]          coreRdData;
   always @* begin
      coreHit    = 1'b1;
      coreRdData = 8'h00;
      case (regSel)
         `CCAD_A_INDIRECT: coreRdData = 8'h00;
         `CCAD_A_PCLO:     coreRdData = programCounter_ff[7:0];
         `CCAD_A_STAT:     coreRdData = status_ff;
         `CCAD_A_PTR:      coreRdData = ptrReg_ff;
         `CCAD_A_PCHI:     coreRdData = {3'b000, pcHi_ff};
         default:          coreHit    = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // alu
   reg  [7:0] opB;
   reg  [7:0] aluRes;
   reg        aluC;
   reg        aluDc;
   reg        wrC;
   reg        wrDc;
   reg        wrZ;
   reg        toW;
   reg        toFile;
   reg        doSkip;
   reg        skipOnZero;
   reg        doJump;
   reg        doCall;
   reg        doRet;
   reg        doRetIe;
   always @* begin
      opB = isLit ? literal : operand_ff;
      aluRes = opB;
      aluC = status_ff[`CCAD_ST_C];
      aluDc = status_ff[`CCAD_ST_DCY];
      wrC = 1'b0;
      wrDc = 1'b0;
      wrZ = 1'b0;
      toW = 1'b0;
      toFile = 1'b0;
      doSkip = 1'b0;
      skipOnZero = 1'b0;
      doJump = 1'b0;
      doCall = 1'b0;
      doRet = 1'b0;
      doRetIe = 1'b0;
      case (opClass)
         `CCAD_CLS_BYTE: begin
            toW = ~destFile;
            toFile = destFile;
            wrZ = 1'b1;
            case (opCode)
               `CCAD_OP_MOVW: begin
                  aluRes = wReg_ff;
                  wrZ = 1'b0;
                  toW = 1'b0;
                  doRetIe = ~destFile && (fileSel == `CCAD_F_RETIE);
                  doRet = ~destFile && ((fileSel == `CCAD_F_RET) ||
                                        doRetIe);
               end
               `CCAD_OP_CLR:  aluRes = 8'h00;
               `CCAD_OP_SUB: begin
                  {aluC, aluDc, aluRes} = addc(opB, ~wReg_ff, 1'b1);
                  wrC = 1'b1;
                  wrDc = 1'b1;
               end
               `CCAD_OP_DEC:  {aluC, aluDc, aluRes} = addc(opB, 8'hFF, 1'b0);
               `CCAD_OP_IOR:  aluRes = opB | wReg_ff;
               `CCAD_OP_AND:  aluRes = opB & wReg_ff;
               `CCAD_OP_XOR:  aluRes = opB ^ wReg_ff;
               `CCAD_OP_ADD: begin
                  {aluC, aluDc, aluRes} = addc(opB, wReg_ff, 1'b0);
                  wrC = 1'b1;
                  wrDc = 1'b1;
               end
               `CCAD_OP_MOV:  aluRes = opB;
               `CCAD_OP_COM:  aluRes = ~opB;
               `CCAD_OP_INC:  {aluC, aluDc, aluRes} = addc(opB, 8'h01, 1'b0);
               `CCAD_OP_DECSZ: begin
                  {aluC, aluDc, aluRes} = addc(opB, 8'hFF, 1'b0);
                  wrZ = 1'b0;
                  skipOnZero = 1'b1;
               end
               `CCAD_OP_RRF: begin
                  aluRes = {status_ff[`CCAD_ST_C], opB[7:1]};
                  aluC = opB[0];
                  wrC = 1'b1;
                  wrZ = 1'b0;
               end
               `CCAD_OP_RLF: begin
                  aluRes = {opB[6:0], status_ff[`CCAD_ST_C]};
                  aluC = opB[7];
                  wrC = 1'b1;
                  wrZ = 1'b0;
               end
               `CCAD_OP_SWAP: begin
                  aluRes = {opB[3:0], opB[7:4]};
                  wrZ = 1'b0;
               end
               default: begin
                  {aluC, aluDc, aluRes} = addc(opB, 8'h01, 1'b0);
                  wrZ = 1'b0;
                  skipOnZero = 1'b1;
               end
            endcase
         end
         `CCAD_CLS_BIT: begin
            case (opCode[3:2])
               2'b00:   begin aluRes = opB & ~bitMask; toFile = 1'b1; end
               2'b01:   begin aluRes = opB | bitMask;  toFile = 1'b1; end
               2'b10:   doSkip = ((opB & bitMask) == 8'h00);
               default: doSkip = ((opB & bitMask) != 8'h00);
            endcase
         end
         `CCAD_CLS_JUMP: begin
            doJump = 1'b1;
            doCall = ~instr_ff[11];
         end
         default: begin
            toW = 1'b1;
            casez (opCode)
               `CCAD_LOP_MOVE: aluRes = literal;
               `CCAD_LOP_RET:  begin aluRes = literal; doRet = 1'b1; end
               `CCAD_LOP_IOR:  begin aluRes = literal | wReg_ff; wrZ = 1'b1; end
               `CCAD_LOP_AND:  begin aluRes = literal & wReg_ff; wrZ = 1'b1; end
               `CCAD_LOP_XOR:  begin aluRes = literal ^ wReg_ff; wrZ = 1'b1; end
               `CCAD_LOP_SUB: begin
                  {aluC, aluDc, aluRes} = addc(literal, ~wReg_ff, 1'b1);
                  wrC = 1'b1;
                  wrDc = 1'b1;
                  wrZ = 1'b1;
               end
               `CCAD_LOP_ADD: begin
                  {aluC, aluDc, aluRes} = addc(literal, wReg_ff, 1'b0);
                  wrC = 1'b1;
                  wrDc = 1'b1;
                  wrZ = 1'b1;
               end
               default: toW = 1'b0;
            endcase
         end
      endcase
      if (skipOnZero)
         doSkip = (aluRes == 8'h00);
   end

   ////////////////////////////////////////////////////////////////////////
   // commit decisions
   wire fileWr   = toFile && coreHit;
   wire extWr    = toFile && !coreHit;
   wire pcWrite  = fileWr && (regSel == `CCAD_A_PCLO);
   wire redirect = doJump | doRet | pcWrite | doSkip;
   wire irqTake  = intReq && irqEnable_ff && !redirect;

   reg  [7:0]            nxt_status;
   reg  [`CCAD_PC_W-1:0] nxt_pc;
   always @* begin
      nxt_status = (fileWr && regSel == `CCAD_A_STAT) ? aluRes : status_ff;
      if (wrC)
         nxt_status[`CCAD_ST_C] = aluC;
      if (wrDc)
         nxt_status[`CCAD_ST_DCY] = aluDc;
      if (wrZ)
         nxt_status[`CCAD_ST_Z] = (aluRes == 8'h00);
      if (doJump)
         nxt_pc = {pcHi_ff[4:3], instr_ff[10:0]};
      else if (doRet)
         nxt_pc = stack_ff[sp_ff - 1'b1];
      else if (pcWrite)
         nxt_pc = {pcHi_ff, aluRes};
      else if (irqTake)
         nxt_pc = programCounter_ff; // word not consumed, kept for return
      else
         nxt_pc = programCounter_ff + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer and state
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mclrMeta_ff <= 1'b0;
         mclrSync_ff <= 1'b0;
      end else if (ce) begin
         mclrMeta_ff <= masterClearInN;
         mclrSync_ff <= mclrMeta_ff;
      end
   end

   integer i;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_ff <= PH_Q1;
         programCounter_ff <= `CCAD_RESET_VEC;
         instr_ff <= `CCAD_NOP;
         wReg_ff <= 8'h00;
         status_ff <= `CCAD_STATUS_RST;
         ptrReg_ff <= 8'h00;
         pcHi_ff <= 5'h00;
         operand_ff <= 8'h00;
         sp_ff <= {SP_W{1'b0}};
         dataAddr_ff <= 8'h00;
         dataWrData_ff <= 8'h00;
         dataRdEn_ff <= 1'b0;
         dataWrEn_ff <= 1'b0;
         intAck_ff <= 1'b0;
         irqEnable_ff <= 1'b1;
         instr_rate_clock_out_ff <= 1'b0;
         for (i = 0; i < STACK_DEPTH; i = i + 1)
            stack_ff[i] <= `CCAD_RESET_VEC;
      end else if (ce) begin
         intAck_ff <= 1'b0;
         // high across the last two phases: quarter rate, half duty
         instr_rate_clock_out_ff <= rcModeSel && (phase_ff == PH_Q2 ||
                                    phase_ff == PH_Q3);
         if (coreRst) begin
            phase_ff <= PH_Q1;
            programCounter_ff <= `CCAD_RESET_VEC;
            instr_ff <= `CCAD_NOP;
            status_ff <= `CCAD_STATUS_RST;
            sp_ff <= {SP_W{1'b0}};
            dataRdEn_ff <= 1'b0;
            dataWrEn_ff <= 1'b0;
            irqEnable_ff <= 1'b1;
         end else begin
            case (phase_ff)
               PH_Q1: begin
                  phase_ff <= PH_Q2;
                  dataAddr_ff <= effAddr;
                  dataRdEn_ff <= !isLit && !coreHit;
               end
               PH_Q2: begin
                  phase_ff <= PH_Q3;
                  dataRdEn_ff <= 1'b0;
                  operand_ff <= coreHit ? coreRdData : dataRdData;
               end
               PH_Q3: begin
                  phase_ff <= PH_Q4;
                  dataWrEn_ff <= extWr;
                  dataWrData_ff <= aluRes;
               end
               PH_Q4: begin
                  phase_ff <= PH_Q1;
                  dataWrEn_ff <= 1'b0;
                  status_ff <= nxt_status;
                  if (toW)
                     wReg_ff <= aluRes;
                  if (fileWr && regSel == `CCAD_A_PTR)
                     ptrReg_ff <= aluRes;
                  if (fileWr && regSel == `CCAD_A_PCHI)
                     pcHi_ff <= aluRes[4:0];
                  if (doCall) begin
                     stack_ff[sp_ff] <= programCounter_ff;
                     sp_ff <= sp_ff + 1'b1;
                  end else if (doRet)
                     sp_ff <= sp_ff - 1'b1;
                  if (doRetIe)
                     irqEnable_ff <= 1'b1;
                  programCounter_ff <= nxt_pc;
                  // the word fetched alongside a branch is dropped
                  if (redirect)
                     instr_ff <= `CCAD_NOP;
                  else if (irqTake) begin
                     instr_ff <= `CCAD_IRQ_CALL;
                     irqEnable_ff <= 1'b0;
                     intAck_ff <= 1'b1;
                  end else
                     instr_ff <= progData;
               end
               default: phase_ff <= PH_Q1;
            endcase
         end
      end
   end

   assign progAddr = programCounter_ff[`CCAD_PROG_AW-1:0];
   assign dataAddr = dataAddr_ff;
   assign dataRdEn = dataRdEn_ff;
   assign dataWrEn = dataWrEn_ff;
   assign dataWrData = dataWrData_ff;
   assign intAck = intAck_ff;
   assign instrRateClockOut = instr_rate_clock_out_ff;
endmodule // ccad_core

// >>> ccad_core_asserts.sv
// concurrent checks on the core's memory strobes, clock output and reset
`timescale 1ns/100ps
module ccad_chk (
   input wire        clk,               // clock
   input wire        rst,               // async reset
   input wire        ce,                // clock enable
   input wire        masterClearInN,    // master clear, low active
   input wire        rcModeSel,         // rc mode select
   input wire [11:0] progAddr,          // program address
   input wire [13:0] progData,          // program word
   input wire [7:0]  dataAddr,          // data address
   input wire        dataRdEn,          // read strobe
   input wire [7:0]  dataRdData,        // read value
   input wire        dataWrEn,          // write strobe
   input wire [7:0]  dataWrData,        // write value
   input wire        intReq,            // interrupt request
   input wire        intAck,            // interrupt taken
   input wire        instrRateClockOut  // quarter-rate clock
);
////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_RDEN_ONE: assert property (dataRdEn |=> !dataRdEn [*3])
      else $error("read strobe longer than one clock");
   AST_WR_PAIR: assert property (dataWrEn |-> $past(dataRdEn, 2)
      && dataAddr == $past(dataAddr, 2))
      else $error("write not two clocks after read of same address");
   // master clear cuts a cycle short, so phase checks pause during it
   AST_PC_STEP: assert property (disable iff (rst || !masterClearInN)
      $changed(progAddr) |=> $stable(progAddr) [*3])
      else $error("program address changed inside a cycle");
   AST_PC_WRAP: assert property ($past(progAddr) == 12'hFFF
      && $changed(progAddr) |-> progAddr == 12'h000)
      else $error("program address did not wrap to zero");
   AST_MASTER_CLEAR_IN_HOLD: assert property (!masterClearInN [*5] |->
      progAddr == 12'h000 && !dataWrEn && !dataRdEn)
      else $error("core runs while master clear is low");
   AST_CLK_QUARTER: assert property (disable iff (rst || !masterClearInN)
      rcModeSel && $rose(instrRateClockOut) |=> instrRateClockOut
      ##1 !instrRateClockOut ##1 !instrRateClockOut ##1 instrRateClockOut)
      else $error("clock output not a quarter of the clock");
   AST_CLK_OFF: assert property (!rcModeSel && !$past(rcModeSel)
      |-> !instrRateClockOut)
      else $error("clock output active outside rc mode");
   AST_RD_PHASE: assert property (disable iff (rst || !masterClearInN)
      rcModeSel && dataRdEn |-> !instrRateClockOut ##1 instrRateClockOut)
      else $error("read strobe outside the second phase");
   AST_WR_PHASE: assert property (disable iff (rst || !masterClearInN)
      rcModeSel && dataWrEn |-> instrRateClockOut ##1 !instrRateClockOut)
      else $error("write strobe outside the fourth phase");
   AST_INTACK_ONE: assert property (intAck |=> !intAck)
      else $error("interrupt acknowledge longer than one clock");
   AST_INT_VECTOR: assert property (intAck |-> ##[1:8] progAddr == 12'h004)
      else $error("interrupt did not reach its vector");
endmodule // ccad_chk

bind ccad_core ccad_chk i_chk (.clk(clk), .rst(rst), .ce(ce),
   .masterClearInN(masterClearInN), .rcModeSel(rcModeSel),
   .progAddr(progAddr), .progData(progData), .dataAddr(dataAddr),
   .dataRdEn(dataRdEn), .dataRdData(dataRdData), .dataWrEn(dataWrEn),
   .dataWrData(dataWrData), .intReq(intReq), .intAck(intAck),
   .instrRateClockOut(instrRateClockOut));

// >>> ccad_mem_model.sv
// program rom and data ram seen by the core
`timescale 1ns/100ps
module ccad_mem_model (
   input  wire        clk,        // clock
   input  wire [11:0] progAddr,   // program address
   output wire [13:0] progData,   // program word
   input  wire [7:0]  dataAddr,   // data address
   input  wire        dataRdEn,   // read strobe
   output wire [7:0]  dataRdData, // read value
   input  wire        dataWrEn,   // write strobe
   input  wire [7:0]  dataWrData  // write value
);
////////////////////////////////////////////////////////////
   logic [13:0] rom [0:4095];
   logic [7:0]  ram [0:255];
   logic [7:0]  lastRd_ff = 8'h00;

   assign progData = rom[progAddr];
   // inverted old value when idle, so a stray sample cannot look right
   assign dataRdData = dataRdEn ? ram[dataAddr] : ~lastRd_ff;

   always @(posedge clk) begin
      if (dataRdEn)
         lastRd_ff <= ram[dataAddr];
      if (dataWrEn)
         ram[dataAddr] <= dataWrData;
   end
endmodule // ccad_mem_model

// >>> cpu_core_alu_datapath_tb_top.sv
// self-checking bench: random alu programs run from the memory model
`timescale 1ns/100ps
module cpu_core_alu_datapath_tb_top;
   localparam int NT = 12;
   localparam int BASE = 16;
   localparam int EX = BASE + 6 * NT;
   localparam int GT = EX + 14;
   reg          clk = 0, rst = 1, ce = 1, masterClearInN = 1;
   reg          rcModeSel = 1, intReq = 0;
   wire [11:0]  progAddr;
   wire [13:0]  progData;
   wire [7:0]   dataAddr, dataRdData, dataWrData;
   wire         dataRdEn, dataWrEn, intAck, instrRateClockOut;
   int          seed = 45922, err_total = 0, checked = 0, cyc = 0, acks = 0;
   logic [7:0]  expRes [0:NT-1];
   logic [7:0]  expSt [0:NT-1];
   logic        fc, fdc, fz;

   ccad_core i_dut (.clk(clk), .rst(rst), .ce(ce),
      .masterClearInN(masterClearInN), .rcModeSel(rcModeSel),
      .progAddr(progAddr), .progData(progData), .dataAddr(dataAddr),
      .dataRdEn(dataRdEn), .dataRdData(dataRdData), .dataWrEn(dataWrEn),
      .dataWrData(dataWrData), .intReq(intReq), .intAck(intAck),
      .instrRateClockOut(instrRateClockOut));
   ccad_mem_model i_mem (.clk(clk), .progAddr(progAddr),
      .progData(progData), .dataAddr(dataAddr), .dataRdEn(dataRdEn),
      .dataRdData(dataRdData), .dataWrEn(dataWrEn),
      .dataWrData(dataWrData));

   always #20 clk = ~clk;
   // counted on the falling edge, half a clock after launch, so the pulse is settled
   always @(negedge clk) acks += intAck;
////////////////////////////////////////////////////////////
   function automatic logic [7:0] alu(input int op, input logic [7:0] a, b);
      logic [8:0] s;
      s = 9'h000;
      case (op)
         0: begin s = a + b; fdc = (a[3:0] + b[3:0]) > 15; fc = s[8]; end
         1: begin s = b - a; fdc = b[3:0] >= a[3:0]; fc = b >= a; end
         2: s = a & b;
         3: s = a | b;
         4: s = a ^ b;
         default: begin s = {a, fc}; fc = a[7]; end
      endcase
      if (op < 5)
         fz = s[7:0] == 8'h00;
      return s[7:0];
   endfunction

   // literal opcodes in the order of the alu model's op numbers
   function automatic logic [13:0] lop(input int op);
      case (op)
         0: lop = 14'h3E00;
         1: lop = 14'h3C00;
         2: lop = 14'h3900;
         3: lop = 14'h3800;
         default: lop = 14'h3A00;
      endcase
   endfunction

   task automatic build();
      int op, i, w;
      logic [7:0] a, b;
      for (i = 0; i < 4096; i++) i_mem.rom[i] = 14'h0000;
      i_mem.rom[0] = 14'h2800 | 14'(BASE);
      i_mem.rom[4] = 14'h305A;
      i_mem.rom[5] = 14'h00F0;
      fc = 0; fdc = 0; fz = 0;
      for (i = 0; i < NT; i++) begin
         a = $random(seed);
         b = $random(seed);
         op = (i < 6) ? i : $unsigned($random(seed)) % 6;
         // corners: sum of zero with carry, borrow from zero
         if (i == 0) begin a = 8'h80; b = 8'h80; end
         if (i == 1) begin a = 8'h01; b = 8'h00; end
         w = BASE + 6 * i;
         i_mem.rom[w] = 14'h3000 | {6'h00, a};
         i_mem.rom[w+1] = op < 5 ? lop(op) | {6'h00, b} : 14'h00E0;
         i_mem.rom[w+2] = op < 5 ? 14'h0000 : 14'h0D60;
         i_mem.rom[w+3] = 14'h00A0 + 14'(2 * i);
         i_mem.rom[w+4] = 14'h0803;
         i_mem.rom[w+5] = 14'h00A1 + 14'(2 * i);
         expRes[i] = alu(op, a, b);
         expSt[i] = {5'b00011, fz, fdc, fc};
         fz = 0;
      end
      // pointer store and swap, call with skip and table return, counter read
      i_mem.rom[EX] = 14'h3050;
      i_mem.rom[EX+1] = 14'h0084;
      i_mem.rom[EX+2] = 14'h30C3;
      i_mem.rom[EX+3] = 14'h0080;
      i_mem.rom[EX+4] = 14'h0E00;
      i_mem.rom[EX+5] = 14'h00D3;
      i_mem.rom[EX+6] = 14'h2000 | 14'(EX + 9);
      i_mem.rom[EX+7] = 14'h00D1;
      i_mem.rom[EX+8] = 14'h2800 | 14'(EX + 12);
      i_mem.rom[EX+9] = 14'h1C50;
      i_mem.rom[EX+10] = 14'h34EE;
      i_mem.rom[EX+11] = 14'h3477;
      i_mem.rom[EX+12] = 14'h0802;
      i_mem.rom[EX+13] = 14'h00D2;
      // the skipped word would store a nonzero w into the marker
      i_mem.rom[GT] = 14'h2800 | 14'(GT + 2);
      i_mem.rom[GT+1] = 14'h00FF;
   endtask

   task automatic chk(input logic [11:0] got, exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_pc(input logic [11:0] a, input int lim);
      int n;
      n = 0;
      while (progAddr !== a && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(progAddr, a);
   endtask

   task automatic clr_ram();
      for (int i = 0; i < 256; i++) i_mem.ram[i] = 8'h00;
   endtask

   task automatic chk_ram();
      for (int i = 0; i < NT; i++) begin
         chk({4'h0, i_mem.ram[8'h20+2*i]}, {4'h0, expRes[i]});
         chk({4'h0, i_mem.ram[8'h21+2*i]}, {4'h0, expSt[i]});
      end
      chk({4'h0, i_mem.ram[8'h50]}, 12'h0C3);
      chk({4'h0, i_mem.ram[8'h53]}, 12'h03C);
      chk({4'h0, i_mem.ram[8'h51]}, 12'h077);
      chk({4'h0, i_mem.ram[8'h52]}, 12'(EX + 13));
      chk({4'h0, i_mem.ram[8'h7F]}, 12'h000);
   endtask

   task automatic rate_chk();
      int r;
      logic p;
      r = 0;
      p = instrRateClockOut;
      repeat (40) begin
         @(negedge clk);
         r += (instrRateClockOut && !p);
         p = instrRateClockOut;
      end
      chk(r[11:0], rcModeSel ? 12'h00A : 12'h000);
   endtask

   task automatic final_report();
      $display("errors %0d of %0d checks", err_total, checked);
      if (err_total == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         final_report();
      end
   end
////////////////////////////////////////////////////////////
   initial begin
      build();
      clr_ram();
      repeat (6) @(negedge clk);
      rst = 0;
      wait_pc(12'(GT + 3), 2000);
      chk_ram();
      rate_chk();
      for (int k = 0; k < 2; k++) begin
         clr_ram();
         masterClearInN = 0;
         rcModeSel = (k == 1);
         repeat (6) @(negedge clk);
         masterClearInN = 1;
         wait_pc(12'(GT + 3), 2000);
         chk_ram();
         rate_chk();
      end
      clr_ram();
      intReq = 1;
      wait_pc(12'h004, 40);
      intReq = 0;
      wait_pc(12'h008, 40);
      chk(12'(acks), 12'h001);
      chk({4'h0, i_mem.ram[8'h70]}, 12'h05A);
      wait_pc(12'hFFF, 20000);
      clr_ram();
      wait_pc(12'(GT + 3), 2000);
      chk_ram();
      final_report();
   end
endmodule // cpu_core_alu_datapath_tb_top
